// [hdl/rsw_defs.svh]
// Constants for the receive status word builder
`ifndef RSW_DEFS_SVH
`define RSW_DEFS_SVH

// Status word field positions
`define RSW_BIT_FILTER_FAIL 30
`define RSW_LEN_HI 29
`define RSW_LEN_LO 16
`define RSW_BIT_ERR_SUMMARY 15
`define RSW_BIT_BCAST 13
`define RSW_BIT_LEN_MISMATCH 12
`define RSW_BIT_RUNT 11
`define RSW_BIT_MCAST 10
`define RSW_BIT_TOO_LONG 7
`define RSW_BIT_LATE_COL 6
`define RSW_BIT_FRAME_TYPE 5
`define RSW_BIT_WDOG 4
`define RSW_BIT_MII_ERR 3
`define RSW_BIT_DRIBBLE 2
`define RSW_BIT_CRC_ERR 1

// Control register field
`define RSW_CTRL_PASS_BAD_BIT 16

// Frame length limits in bytes, and the 14-bit length count width
`define RSW_LEN_W 14
`define RSW_COL_WINDOW 14'h0040
`define RSW_MAX_FRAME 14'h05EE
`define RSW_MIN_HEADER 14'h000E
`define RSW_MAX_LEN_FIELD 16'h05DC
`define RSW_MIN_PAYLOAD 16'h002E
`define RSW_HDR_FCS 14'h0012
`define RSW_WDOG_LIMIT 2048

// Dribble thresholds in bits
`define RSW_DRIB_MII 3'h4
`define RSW_DRIB_10M 3'h3

// Status queue depth
`define RSW_QUEUE_DEPTH 16

`endif

// [hdl/rsw_pkg.sv]
// Types for the receive status word builder
package rsw_pkg;
    typedef enum logic [3:0] {
        RSW_IDLE = 4'h1,
        RSW_RECV = 4'h2,
        RSW_BUILD = 4'h4,
        RSW_WRITE = 4'h8
    } rsw_state_e;
    typedef logic [31:0] rsw_word_t;
endpackage

// [hdl/rsw_addr_class.sv]
// Destination address class and length/type capture from the header bytes
`timescale 1ns/100ps
`include "rsw_defs.svh"
module rsw_addr_class (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clear,
    input wire logic byte_valid,
    input wire logic [7:0] byte_data,
    input wire logic [`RSW_LEN_W-1:0] byte_index,
    output logic is_bcast,
    output logic is_mcast,
    output logic [15:0] len_type
);
    logic all_ones_reg, all_ones_next;
    logic group_reg, group_next;
    logic [15:0] len_type_reg, len_type_next;

    always_comb begin
        all_ones_next = all_ones_reg;
        group_next = group_reg;
        len_type_next = len_type_reg;
        if (clear) begin
            all_ones_next = 1'b1;
            group_next = 1'b0;
            len_type_next = 16'h0000;
        end else if (byte_valid) begin
            if (byte_index < 14'h0006 && byte_data != 8'hFF) begin
                all_ones_next = 1'b0;
            end
            if (byte_index == 14'h0000) begin
                group_next = byte_data[0];
            end
            if (byte_index == 14'h000C) begin
                len_type_next = {byte_data, len_type_reg[7:0]};
            end else if (byte_index == 14'h000D) begin
                len_type_next = {len_type_reg[15:8], byte_data};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            all_ones_reg <= 1'b1;
            group_reg <= 1'b0;
            len_type_reg <= 16'h0000;
        end else begin
            all_ones_reg <= all_ones_next;
            group_reg <= group_next;
            len_type_reg <= len_type_next;
        end
    end

    // Address is only meaningful once all six bytes are in; caller checks length
    assign is_bcast = all_ones_reg;
    assign is_mcast = group_reg & ~all_ones_reg;
    assign len_type = len_type_reg;
endmodule

// [hdl/rsw_status_queue.sv]
// Receive status queue holding finished status words for the host
`timescale 1ns/100ps
module rsw_status_queue #(
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic push,
    input wire logic [31:0] push_word,
    input wire logic pop,
    output logic [31:0] rd_data,
    output logic rd_valid,
    output logic [AW:0] count,
    output logic overrun,
    output logic underrun
);
    logic [31:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
    logic [AW:0] count_reg, count_next;
    logic [31:0] rd_data_reg, rd_data_next;
    logic rd_valid_reg, rd_valid_next, overrun_reg, overrun_next;
    logic underrun_reg, underrun_next, do_push, do_pop;

    always_comb begin
        do_pop = pop && count_reg != '0;
        do_push = push && (count_reg != DEPTH[AW:0] || do_pop);
        wr_ptr_next = do_push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
        rd_ptr_next = do_pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
        count_next = count_reg + {{AW{1'b0}}, do_push} - {{AW{1'b0}}, do_pop};
        rd_data_next = do_pop ? mem[rd_ptr_reg] : 32'h00000000;
        rd_valid_next = do_pop;
        overrun_next = push && !do_push;
        underrun_next = pop && !do_pop;
    end

    // Storage has no reset; only the count and pointers decide what is valid
    always_ff @(posedge clk) begin
        if (do_push) begin
            mem[wr_ptr_reg] <= push_word;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
            rd_data_reg <= 32'h00000000;
            rd_valid_reg <= 1'b0;
            overrun_reg <= 1'b0;
            underrun_reg <= 1'b0;
        end else begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            count_reg <= count_next;
            rd_data_reg <= rd_data_next;
            rd_valid_reg <= rd_valid_next;
            overrun_reg <= overrun_next;
            underrun_reg <= underrun_next;
        end
    end

    assign rd_data = rd_data_reg;
    assign rd_valid = rd_valid_reg;
    assign count = count_reg;
    assign overrun = overrun_reg;
    assign underrun = underrun_reg;
endmodule

// [hdl/rsw_builder.sv]
// Receive status word builder: per-frame error tracking, word assembly, queueing
//
// Behaviour
// - Bits 31, 14, 9:8 and 0 of every status word read zero.
// - Bit 30 set when the frame failed destination address filtering.
// - Bits 29:16 carry the received frame byte count.
// - Bit 15 is the OR of runt, too-long, late-collision and CRC bits.
// - Bit 13 set for a broadcast destination address.
// - Bit 12 set when measured length disagrees with the length/type field.
// - Bit 11 set when the frame ended before 64 bytes.
// - Runt frames reach the host only with control bit 16 set, else dropped.
// - Bit 10 set for a multicast destination address.
// - Bit 7 set when the frame exceeds 1518 bytes.
// - Over-length frames are still received and counted, the count saturating at 16383 bytes.
// - Bit 6 set for a collision seen after the collision window.
// - Bit 5 set when length/type exceeds 1500, clear for length form.
// - Bit 5 stays clear for runts shorter than 14 bytes.
// - Bit 4 set when the frame grows past the receive watchdog limit.
// - Bit 3 set if receive error was seen at any time during the frame.
// - Bit 2 set when the bit count is not a multiple of eight.
// - Dribble only for 4 trailing bits on MII, at least 3 at 10 Mbps.
// - Dribble is suppressed whenever the late-collision bit is set.
// - Bit 1 set on FCS mismatch, and also whenever receive error was seen.
// - Status word is queued apart from data, after the frame data ends.
`timescale 1ns/100ps
`include "rsw_defs.svh"
module rsw_builder #(
    parameter int WDOG_LIMIT = `RSW_WDOG_LIMIT,
    parameter int QUEUE_DEPTH = `RSW_QUEUE_DEPTH,
    parameter int QUEUE_AW = 4
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [31:0] mac_control_reg,
    input wire logic rx_frame_start,
    input wire logic rx_byte_valid,
    input wire logic [7:0] rx_byte,
    input wire logic rx_er,
    input wire logic rx_collision,
    input wire logic rx_frame_end,
    input wire logic [2:0] rx_dribble_bits,
    input wire logic rx_crc_ok,
    input wire logic rx_filter_fail,
    input wire logic rx_mode_10m,
    input wire logic status_rd,
    output logic [31:0] status_rd_data,
    output logic status_rd_valid,
    output logic [QUEUE_AW:0] status_count,
    output logic status_overrun,
    output logic status_underrun,
    output logic frame_discard,
    output logic frame_queued,
    output logic rx_busy
);
    // Watchdog limit must sit in 2048..2560; kept at the 14-bit count width
    localparam logic [`RSW_LEN_W-1:0] WDOG_LEN = WDOG_LIMIT[`RSW_LEN_W-1:0];

    rsw_pkg::rsw_state_e state_reg, state_next;

    logic [`RSW_LEN_W-1:0] count_reg, count_next;
    logic er_seen_reg, er_seen_next;
    logic late_col_reg, late_col_next;
    logic wdog_reg, wdog_next;
    logic [2:0] drib_reg, drib_next;
    logic crc_ok_reg, crc_ok_next;
    logic filt_fail_reg, filt_fail_next;
    logic mode_10m_reg, mode_10m_next;
    logic pass_bad_reg, pass_bad_next;
    rsw_pkg::rsw_word_t word_reg, word_next;
    logic push_reg, push_next;
    logic discard_reg, discard_next;
    logic queued_reg, queued_next;
    logic busy_reg, busy_next;

    logic clear_frame;
    logic hdr_bcast, hdr_mcast;
    logic [15:0] hdr_len_type;

    // Assembly terms, computed from the frame's registered state
    logic runt, too_long, has_header, type_form, dribble, crc_err, err_sum;
    logic len_mismatch;
    logic [`RSW_LEN_W-1:0] payload_len;

    always_comb begin
        clear_frame = (state_reg == rsw_pkg::RSW_IDLE || state_reg == rsw_pkg::RSW_RECV)
            && rx_frame_start;
    end

    rsw_addr_class u_addr_class (
        .clk(clk),
        .sys_rst(sys_rst),
        .clear(clear_frame),
        .byte_valid(rx_byte_valid && state_reg == rsw_pkg::RSW_RECV),
        .byte_data(rx_byte),
        .byte_index(count_reg),
        .is_bcast(hdr_bcast),
        .is_mcast(hdr_mcast),
        .len_type(hdr_len_type)
    );

    // Frame state machine
    always_comb begin
        state_next = state_reg;
        busy_next = busy_reg;
        case (state_reg)
            rsw_pkg::RSW_IDLE: begin
                if (rx_frame_start) begin
                    state_next = rsw_pkg::RSW_RECV;
                    busy_next = 1'b1;
                end
            end
            rsw_pkg::RSW_RECV: begin
                // Too-long does not end the frame; only the end strobe does
                if (rx_frame_end && !rx_frame_start) begin
                    state_next = rsw_pkg::RSW_BUILD;
                end
            end
            rsw_pkg::RSW_BUILD: begin
                state_next = rsw_pkg::RSW_WRITE;
            end
            rsw_pkg::RSW_WRITE: begin
                state_next = rsw_pkg::RSW_IDLE;
                busy_next = 1'b0;
            end
            default: begin
                state_next = rsw_pkg::RSW_IDLE;
                busy_next = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_reg <= rsw_pkg::RSW_IDLE;
            busy_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            busy_reg <= busy_next;
        end
    end

    // Per-frame event tracking while bytes arrive
    always_comb begin
        count_next = count_reg;
        er_seen_next = er_seen_reg;
        late_col_next = late_col_reg;
        wdog_next = wdog_reg;
        drib_next = drib_reg;
        crc_ok_next = crc_ok_reg;
        filt_fail_next = filt_fail_reg;
        mode_10m_next = mode_10m_reg;
        pass_bad_next = pass_bad_reg;
        if (clear_frame) begin
            count_next = '0;
            er_seen_next = 1'b0;
            late_col_next = 1'b0;
            wdog_next = 1'b0;
            drib_next = 3'h0;
            crc_ok_next = 1'b1;
            filt_fail_next = 1'b0;
            mode_10m_next = 1'b0;
            pass_bad_next = 1'b0;
        end else if (state_reg == rsw_pkg::RSW_RECV) begin
            // Count saturates rather than wrapping on huge frames
            if (rx_byte_valid && count_reg != {`RSW_LEN_W{1'b1}}) begin
                count_next = count_reg + 1'b1;
            end
            if (rx_er) begin
                er_seen_next = 1'b1;
            end
            if (rx_collision && count_reg >= `RSW_COL_WINDOW) begin
                late_col_next = 1'b1;
            end
            if (count_reg > WDOG_LEN) begin
                wdog_next = 1'b1;
            end
            if (rx_frame_end) begin
                drib_next = rx_dribble_bits;
                crc_ok_next = rx_crc_ok;
                filt_fail_next = rx_filter_fail;
                mode_10m_next = rx_mode_10m;
                pass_bad_next = mac_control_reg[`RSW_CTRL_PASS_BAD_BIT];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            count_reg <= '0;
            er_seen_reg <= 1'b0;
            late_col_reg <= 1'b0;
            wdog_reg <= 1'b0;
            drib_reg <= 3'h0;
            crc_ok_reg <= 1'b1;
            filt_fail_reg <= 1'b0;
            mode_10m_reg <= 1'b0;
            pass_bad_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            er_seen_reg <= er_seen_next;
            late_col_reg <= late_col_next;
            wdog_reg <= wdog_next;
            drib_reg <= drib_next;
            crc_ok_reg <= crc_ok_next;
            filt_fail_reg <= filt_fail_next;
            mode_10m_reg <= mode_10m_next;
            pass_bad_reg <= pass_bad_next;
        end
    end

    // Field derivation
    always_comb begin
        runt = count_reg < `RSW_COL_WINDOW;
        too_long = count_reg > `RSW_MAX_FRAME;
        has_header = count_reg >= `RSW_MIN_HEADER;
        type_form = has_header && hdr_len_type > `RSW_MAX_LEN_FIELD;
        payload_len = count_reg - `RSW_HDR_FCS;
        // Short payloads are padded to the minimum frame, so only exact 64 fits
        if (!has_header || type_form || runt) begin
            len_mismatch = 1'b0;
        end else if (hdr_len_type < `RSW_MIN_PAYLOAD) begin
            len_mismatch = count_reg != `RSW_COL_WINDOW;
        end else begin
            len_mismatch = {2'b00, payload_len} != hdr_len_type;
        end
        if (late_col_reg) begin
            dribble = 1'b0;
        end else if (mode_10m_reg) begin
            dribble = drib_reg >= `RSW_DRIB_10M;
        end else begin
            dribble = drib_reg == `RSW_DRIB_MII;
        end
        crc_err = !crc_ok_reg || er_seen_reg;
        err_sum = runt || too_long || late_col_reg || crc_err;
    end

    // Word assembly and queue hand-off after the frame data has ended
    always_comb begin
        word_next = word_reg;
        push_next = 1'b0;
        discard_next = 1'b0;
        queued_next = 1'b0;
        if (state_reg == rsw_pkg::RSW_BUILD) begin
            word_next = 32'h00000000;
            word_next[`RSW_BIT_FILTER_FAIL] = filt_fail_reg;
            word_next[`RSW_LEN_HI:`RSW_LEN_LO] = count_reg;
            word_next[`RSW_BIT_ERR_SUMMARY] = err_sum;
            word_next[`RSW_BIT_BCAST] = has_header && hdr_bcast;
            word_next[`RSW_BIT_LEN_MISMATCH] = len_mismatch;
            word_next[`RSW_BIT_RUNT] = runt;
            word_next[`RSW_BIT_MCAST] = has_header && hdr_mcast;
            word_next[`RSW_BIT_TOO_LONG] = too_long;
            word_next[`RSW_BIT_LATE_COL] = late_col_reg;
            word_next[`RSW_BIT_FRAME_TYPE] = type_form;
            word_next[`RSW_BIT_WDOG] = wdog_reg;
            word_next[`RSW_BIT_MII_ERR] = er_seen_reg;
            word_next[`RSW_BIT_DRIBBLE] = dribble;
            word_next[`RSW_BIT_CRC_ERR] = crc_err;
            if (runt && !pass_bad_reg) begin
                discard_next = 1'b1;
            end else begin
                push_next = 1'b1;
                queued_next = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            word_reg <= 32'h00000000;
            push_reg <= 1'b0;
            discard_reg <= 1'b0;
            queued_reg <= 1'b0;
        end else begin
            word_reg <= word_next;
            push_reg <= push_next;
            discard_reg <= discard_next;
            queued_reg <= queued_next;
        end
    end

    // Separate status queue; data path never sees these words
    rsw_status_queue #(
        .DEPTH(QUEUE_DEPTH),
        .AW(QUEUE_AW)
    ) u_status_queue (
        .clk(clk),
        .sys_rst(sys_rst),
        .push(push_reg),
        .push_word(word_reg),
        .pop(status_rd),
        .rd_data(status_rd_data),
        .rd_valid(status_rd_valid),
        .count(status_count),
        .overrun(status_overrun),
        .underrun(status_underrun)
    );

    assign frame_discard = discard_reg;
    assign frame_queued = queued_reg;
    assign rx_busy = busy_reg;
endmodule

// [verif/rsw_builder_assertions.sv]
// Port-level checks for the receive status word builder
`timescale 1ns/100ps
module rsw_builder_chk #(
    parameter int WDOG_LIMIT = 2048
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [31:0] mac_control_reg,
    input wire logic rx_frame_start,
    input wire logic rx_frame_end,
    input wire logic status_rd,
    input wire logic [31:0] status_rd_data,
    input wire logic status_rd_valid,
    input wire logic status_underrun,
    input wire logic frame_discard,
    input wire logic frame_queued,
    input wire logic rx_busy
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    AST_RSVD_ZERO: assert property (status_rd_valid |-> !status_rd_data[31] &&
        !status_rd_data[14] && status_rd_data[9:8] == 2'h0 && !status_rd_data[0])
        else $error("reserved status bit set");
    AST_ERR_SUMMARY: assert property (status_rd_valid |-> status_rd_data[15] ==
        (status_rd_data[11] | status_rd_data[7] | status_rd_data[6] | status_rd_data[1]))
        else $error("error summary mismatch");
    AST_RUNT_FLAG: assert property (status_rd_valid |->
        status_rd_data[11] == (status_rd_data[29:16] < 14'h0040))
        else $error("runt flag wrong");
    AST_TOO_LONG: assert property (status_rd_valid |->
        status_rd_data[7] == (status_rd_data[29:16] > 14'h05EE))
        else $error("too long flag wrong");
    AST_FTYPE_SHORT: assert property (status_rd_valid &&
        status_rd_data[29:16] < 14'h000E |-> !status_rd_data[5])
        else $error("frame type on short runt");
    AST_WDOG_BELOW: assert property (status_rd_valid &&
        status_rd_data[29:16] <= WDOG_LIMIT |-> !status_rd_data[4])
        else $error("watchdog flag below limit");
    AST_DRIB_LATE: assert property (status_rd_valid |->
        !(status_rd_data[2] && status_rd_data[6]))
        else $error("dribble with late collision");
    AST_MII_CRC: assert property (status_rd_valid && status_rd_data[3] |->
        status_rd_data[1])
        else $error("receive error without crc flag");
    AST_CAST_EXCL: assert property (status_rd_valid |->
        !(status_rd_data[13] && status_rd_data[10]))
        else $error("broadcast and multicast both set");
    AST_END_ANSWER: assert property (rx_frame_end && rx_busy && !rx_frame_start |->
        ##2 (frame_queued ^ frame_discard))
        else $error("no frame result two cycles after end");
    AST_PASS_BAD_KEEP: assert property (rx_frame_end && rx_busy && !rx_frame_start &&
        mac_control_reg[16] |-> ##2 !frame_discard)
        else $error("frame dropped with pass bad set");
    AST_READ_ANSWER: assert property (status_rd |=> status_rd_valid ^ status_underrun)
        else $error("pop not answered");
endmodule
bind rsw_builder rsw_builder_chk #(.WDOG_LIMIT(WDOG_LIMIT)) u_chk (
    .clk(clk),
    .sys_rst(sys_rst),
    .mac_control_reg(mac_control_reg),
    .rx_frame_start(rx_frame_start),
    .rx_frame_end(rx_frame_end),
    .status_rd(status_rd),
    .status_rd_data(status_rd_data),
    .status_rd_valid(status_rd_valid),
    .status_underrun(status_underrun),
    .frame_discard(frame_discard),
    .frame_queued(frame_queued),
    .rx_busy(rx_busy)
);

// [verif/rsw_host_model.sv]
// Host model: pops status words and judges frame usability
`timescale 1ns/100ps
module rsw_host_model (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic pop_req,
    input wire logic status_rd_valid,
    input wire logic [31:0] status_rd_data,
    output logic status_rd,
    output logic [31:0] word,
    output logic good
);
    logic crc_ignored;
    // Strobe is edge aligned by the bench, so pass it straight through
    assign status_rd = pop_req;
    assign crc_ignored = word[11] | word[6] | word[4];
    // Dribble alone does not spoil the frame
    assign good = !(word[11] | word[7] | word[6] | word[4] | word[3]) &&
        (!word[1] || crc_ignored);
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            word <= 32'h0000_0000;
        end else if (status_rd_valid) begin
            word <= status_rd_data;
        end
    end
endmodule

// [verif/rsw_builder_tb.sv]
// Self-checking bench for the receive status word builder
`timescale 1ns/100ps
module rsw_builder_tb;
    localparam int WDOG = 100;
    localparam int NO = 20000;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [31:0] mac_control_reg = 32'h0000_0000;
    logic rx_frame_start = 1'b0, rx_byte_valid = 1'b0, rx_er = 1'b0, rx_collision = 1'b0;
    logic rx_frame_end = 1'b0, rx_crc_ok = 1'b1, rx_filter_fail = 1'b0, rx_mode_10m = 1'b0;
    logic [7:0] rx_byte = 8'h00;
    logic [2:0] rx_dribble_bits = 3'h0;
    logic pop_req = 1'b0;
    logic no_pop = 1'b0;
    logic status_rd, status_rd_valid, status_overrun, status_underrun;
    logic frame_discard, frame_queued, rx_busy, good;
    logic [31:0] status_rd_data, word;
    logic [2:0] status_count;
    int n_fail = 0;
    int comparisons = 0;
    always #2.5 clk = ~clk;
    rsw_builder #(.WDOG_LIMIT(WDOG), .QUEUE_DEPTH(4), .QUEUE_AW(2)) u_dut (
        .clk(clk), .sys_rst(sys_rst), .mac_control_reg(mac_control_reg),
        .rx_frame_start(rx_frame_start), .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte),
        .rx_er(rx_er), .rx_collision(rx_collision), .rx_frame_end(rx_frame_end),
        .rx_dribble_bits(rx_dribble_bits), .rx_crc_ok(rx_crc_ok),
        .rx_filter_fail(rx_filter_fail), .rx_mode_10m(rx_mode_10m), .status_rd(status_rd),
        .status_rd_data(status_rd_data), .status_rd_valid(status_rd_valid),
        .status_count(status_count), .status_overrun(status_overrun),
        .status_underrun(status_underrun), .frame_discard(frame_discard),
        .frame_queued(frame_queued), .rx_busy(rx_busy));
    rsw_host_model u_host (.clk(clk), .sys_rst(sys_rst), .pop_req(pop_req),
        .status_rd_valid(status_rd_valid), .status_rd_data(status_rd_data),
        .status_rd(status_rd), .word(word), .good(good));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic pop();
        @(posedge clk);
        pop_req <= 1'b1;
        @(posedge clk);
        pop_req <= 1'b0;
    endtask
    task automatic frame(input int len, input int kind, input logic [15:0] lt,
        input int er_at, input int col_at, input logic [2:0] drib,
        input logic crc, input logic ff, input logic m10, input logic pb);
        logic [31:0] exp;
        logic runt, late, drop;
        runt = len < 64;
        late = col_at >= 64 && col_at < len;
        drop = runt && !pb;
        exp = 32'h0000_0000;
        exp[30] = ff;
        exp[29:16] = len[13:0];
        exp[13] = kind == 1 && len >= 14;
        exp[12] = !runt && lt <= 16'h05DC && (lt < 16'h002E ? len != 64 : len - 18 != lt);
        exp[11] = runt;
        exp[10] = kind == 2 && len >= 14;
        exp[7] = len > 1518;
        exp[6] = late;
        exp[5] = lt > 16'h05DC && len >= 14;
        exp[4] = len > WDOG;
        exp[3] = er_at < len;
        exp[2] = !late && (m10 ? drib >= 3'h3 : drib == 3'h4);
        exp[1] = !crc || er_at < len;
        exp[15] = exp[11] | exp[7] | exp[6] | exp[1];
        @(posedge clk);
        rx_frame_start <= 1'b1;
        mac_control_reg <= {15'h0000, pb, 16'h0000};
        @(posedge clk);
        rx_frame_start <= 1'b0;
        for (int n = 0; n < len; n++) begin
            rx_byte_valid <= 1'b1;
            rx_byte <= (n < 6) ? (kind == 1 ? 8'hFF : kind == 2 ? 8'h01 : 8'h02) :
                (n == 12) ? lt[15:8] : (n == 13) ? lt[7:0] : n[7:0];
            rx_er <= n == er_at;
            rx_collision <= n == col_at;
            @(posedge clk);
        end
        rx_byte_valid <= 1'b0;
        rx_er <= 1'b0;
        rx_collision <= 1'b0;
        rx_frame_end <= 1'b1;
        rx_dribble_bits <= drib;
        rx_crc_ok <= crc;
        rx_filter_fail <= ff;
        rx_mode_10m <= m10;
        @(posedge clk);
        rx_frame_end <= 1'b0;
        // Result pulse stands only in the cycle after the build stage
        @(posedge clk);
        #1 check({30'h0, frame_discard, frame_queued}, drop ? 32'h2 : 32'h1);
        if (!drop && !no_pop) begin
            @(posedge clk);
            #1 check({28'h0, status_overrun, status_count}, 32'h1);
            pop();
            @(posedge clk);
            #1 check(word, exp);
            check({31'h0, good}, {31'h0, !exp[15] && !exp[4] && !exp[3]});
        end
    endtask
    initial begin
        #200000;
        n_fail++;
        stop_test();
    end
    initial begin
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        pop();
        #1 check({31'h0, status_underrun}, 32'h1);
        frame(64, 1, 16'h0800, NO, NO, 3'h0, 1'b1, 1'b1, 1'b0, 1'b0);
        frame(64, 2, 16'h002E, NO, NO, 3'h0, 1'b1, 1'b0, 1'b0, 1'b0);
        frame(100, 0, 16'h0010, NO, NO, 3'h0, 1'b0, 1'b0, 1'b0, 1'b0);
        frame(60, 1, 16'h0800, NO, NO, 3'h0, 1'b1, 1'b0, 1'b0, 1'b1);
        frame(10, 1, 16'h0800, NO, NO, 3'h0, 1'b1, 1'b0, 1'b0, 1'b1);
        frame(60, 0, 16'h0800, NO, NO, 3'h0, 1'b1, 1'b0, 1'b0, 1'b0);
        frame(1518, 0, 16'h0800, NO, NO, 3'h0, 1'b1, 1'b0, 1'b0, 1'b0);
        frame(1519, 0, 16'h0800, NO, NO, 3'h0, 1'b1, 1'b0, 1'b0, 1'b0);
        frame(80, 0, 16'h0800, 20, NO, 3'h0, 1'b1, 1'b0, 1'b0, 1'b0);
        frame(80, 0, 16'h0800, NO, 10, 3'h4, 1'b1, 1'b0, 1'b0, 1'b0);
        frame(80, 0, 16'h0800, NO, 70, 3'h4, 1'b1, 1'b0, 1'b0, 1'b0);
        frame(80, 0, 16'h0800, NO, NO, 3'h3, 1'b1, 1'b0, 1'b0, 1'b0);
        frame(80, 0, 16'h0800, NO, NO, 3'h3, 1'b1, 1'b0, 1'b1, 1'b0);
        frame(80, 0, 16'h0800, NO, NO, 3'h2, 1'b1, 1'b0, 1'b1, 1'b0);
        frame(64, 0, 16'h0800, NO, NO, 3'h0, 1'b1, 1'b0, 1'b0, 1'b0);
        // Fill the four-word queue unread; the fifth word must be refused
        no_pop = 1'b1;
        repeat (5) frame(64, 0, 16'h0800, NO, NO, 3'h0, 1'b1, 1'b0, 1'b0, 1'b0);
        @(posedge clk);
        #1 check({28'h0, status_overrun, status_count}, 32'h C);
        stop_test();
    end
endmodule
